// file: testbench/fmer_master_model.sv
// network master model: issues state requests, catches reports
// assumes its requests change at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module fmer_master_model (
	// clock
	input wire logic clk_i,
	// state requests
	output logic req_valid_o,
	output logic [2:0] cur_o,
	output logic [2:0] req_o,
	output logic nmt_op_o,
	// report
	input wire logic emcy_valid_i,
	input wire logic [40:0] emcy_rec_i
);
	logic [40:0] last_rec; // last record caught
	int num_rec; // records caught
	initial begin
		req_valid_o = 1'b0;
		cur_o = 3'h0;
		req_o = 3'h0;
		nmt_op_o = 1'b0;
		num_rec = 0;
	end
	// a record stands one cycle only
	always @(posedge clk_i) begin
		if (emcy_valid_i === 1'b1) begin
			last_rec <= emcy_rec_i;
			num_rec <= num_rec + 1;
		end
	end
	task automatic send(input logic [2:0] c, input logic [2:0] r, input logic n);
		@(negedge clk_i);
		req_valid_o = 1'b1;
		cur_o = c;
		req_o = r;
		nmt_op_o = n;
		@(negedge clk_i);
		req_valid_o = 1'b0;
		req_o = ~r; // stale request not kept
	endtask
endmodule // fmer_master_model
`default_nettype wire

// file: testbench/fmer_top_checker.sv
// checker of the fault monitor: flags, reactions and reports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module fmer_top_checker #(
	parameter int XVAL_CYCLES = 4,
	parameter int DVW = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// requests
	input wire logic dsm_req_valid_i,
	input wire logic [2:0] dsm_cur_state_i,
	input wire logic [2:0] dsm_req_state_i,
	input wire logic div_valid_i,
	input wire logic [DVW-1:0] divisor_i,
	// flags and reactions
	input wire logic ov_fault_o,
	input wire logic uv_fault_o,
	input wire logic illegal_fault_o,
	input wire logic divzero_fault_o,
	input wire logic safe_state_o,
	input wire logic fault_hold_req_o,
	input wire logic fault_req_o,
	input wire logic dsm_req_legal_o,
	// report
	input wire logic emcy_valid_o,
	input wire logic [15:0] emcy_code_o,
	input wire logic [7:0] emcy_errreg_o,
	input wire logic [15:0] emcy_index_o,
	input wire logic emcy_severe_o
);
	// room for four queued records, each with its own wait
	localparam int RPT_MAX = 4 * XVAL_CYCLES + 24;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic any_flt = ov_fault_o | uv_fault_o | illegal_fault_o | divzero_fault_o;

	a_zero_div_flag: assert property (div_valid_i && divisor_i == '0 |=> divzero_fault_o)
		else $error("zero divisor not flagged");
	a_div_to_fault: assert property ($rose(divzero_fault_o) |=> fault_req_o [*3])
		else $error("fault request missing");
	a_safe_any: assert property (any_flt |=> safe_state_o)
		else $error("safe state missing");
	a_warn_hold: assert property (any_flt && !divzero_fault_o |=> fault_hold_req_o)
		else $error("fault hold missing");
	a_bad_req: assert property (dsm_req_valid_i && (dsm_cur_state_i == 3'h5 ||
		(dsm_cur_state_i == 3'h0 && dsm_req_state_i == 3'h2)) |=> illegal_fault_o)
		else $error("illegal request not flagged");
	a_good_req: assert property (dsm_req_valid_i && dsm_cur_state_i == 3'h3 &&
		dsm_req_state_i == 3'h2 |=> !illegal_fault_o && dsm_req_legal_o)
		else $error("legal request refused");
	a_dz_record: assert property (emcy_valid_o && emcy_severe_o |->
		emcy_code_o == 16'h6201 && emcy_errreg_o == 8'h81 && emcy_index_o == 16'h2004)
		else $error("division record wrong");
	a_report_due: assert property ($rose(divzero_fault_o) |-> ##[1:RPT_MAX] emcy_valid_o)
		else $error("report late");
	c_ov_up: cover property ($rose(ov_fault_o));
	c_uv_down: cover property ($fell(uv_fault_o));
	c_severe: cover property (emcy_valid_o && emcy_severe_o);
endmodule // fmer_top_checker
bind fmer_top fmer_top_checker #(.XVAL_CYCLES(XVAL_CYCLES), .DVW(DVW)) i_chk (.*);
`default_nettype wire

// file: testbench/fmer_top_tb.sv
// bench of the fault monitor with short tick and wait counts
// assumes the master model and the checker beside it
`timescale 1ns/100ps
`default_nettype none
module fmer_top_tb;
	localparam int TICK = 8;
	logic clk, rst_b, div_valid, nmt, req_valid, ov, uv, il, dz, safe, hold, frq, legal, ev, sev;
	logic [2:0] cur, req;
	logic [7:0] ereg, eerr;
	logic [15:0] pri, sec, divisor, ecode, eidx;
	logic [31:0] seed = 32'h4817909c;
	int num_errors = 0;
	int comparisons = 0;
	fmer_top #(.TICK_CYCLES(TICK), .XVAL_CYCLES(4)) i_fmer_top (.clk_i(clk), .rst_b_i(rst_b),
		.primary_supply_mv_i(pri), .secondary_supply_input_mv_i(sec),
		.dsm_req_valid_i(req_valid), .dsm_cur_state_i(cur), .dsm_req_state_i(req),
		.nmt_operational_i(nmt), .div_valid_i(div_valid), .divisor_i(divisor),
		.ov_fault_o(ov), .uv_fault_o(uv), .illegal_fault_o(il), .divzero_fault_o(dz),
		.error_register_o(ereg), .safe_state_o(safe), .fault_hold_req_o(hold),
		.fault_req_o(frq), .dsm_req_legal_o(legal), .emcy_valid_o(ev),
		.emcy_code_o(ecode), .emcy_errreg_o(eerr), .emcy_index_o(eidx), .emcy_severe_o(sev));
	fmer_master_model i_fmer_master_model (.clk_i(clk), .req_valid_o(req_valid),
		.cur_o(cur), .req_o(req), .nmt_op_o(nmt), .emcy_valid_i(ev),
		.emcy_rec_i({ecode, eerr, eidx, sev}));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic legal_req(input logic [2:0] c, input logic [2:0] r, input logic n);
		case (c)
			3'h0: return r == 3'h1 && n;
			3'h1: return r == 3'h2 || r == 3'h0;
			3'h2, 3'h3, 3'h4: return r == 3'h1 || r == (c == 3'h2 ? 3'h3 : 3'h2);
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic [40:0] exp_rec(input int k);
		case (k)
			0: return {16'h3411, 8'h05, 16'h2001, 1'b0};
			1: return {16'h3412, 8'h05, 16'h2002, 1'b0};
			2: return {16'h5200, 8'h21, 16'h2003, 1'b0};
			default: return {16'h6201, 8'h81, 16'h2004, 1'b1};
		endcase
	endfunction
	task automatic chk(input logic [40:0] got, input logic [40:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_flag(input int k, input logic v, output int n);
		n = 0;
		while ((k == 0 ? ov : uv) !== v && n < 1000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// rise and fall of one supply filter, boundary values count as good
	task automatic filt(input int k);
		int n;
		if (k == 0) pri = 16'h8aad + 16'(rnd() % 16'h1000);
		else sec = 16'(rnd() % 16'h2328);
		wait_flag(k, 1'b1, n);
		chk(n >= 49 * TICK && n <= 52 * TICK, 1'b1);
		pri = 16'h8aac;
		sec = 16'h2328;
		repeat (20) @(negedge clk);
		chk(i_fmer_master_model.last_rec, exp_rec(k));
		chk(i_fmer_master_model.num_rec, k + 1);
		chk({safe, hold, frq, ereg}, {3'b110, 8'h05});
		wait_flag(k, 1'b0, n);
		chk(n >= 46 * TICK && n <= 52 * TICK, 1'b1);
		$display("filter test %0d done", k);
	endtask
	task automatic end_sim();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_sim();
	end
	initial begin
		logic [2:0] c, r;
		logic nb;
		pri = 16'h3000;
		sec = 16'h3000;
		div_valid = 1'b0;
		divisor = 16'h0;
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		filt(0);
		filt(1);
		// corner requests first, then random ones
		for (int i = 0; i < 40; i++) begin
			c = 3'(rnd() % 7);
			r = 3'(rnd() % 7);
			nb = 1'(rnd());
			if (i < 3) {c, r} = i == 0 ? 6'h02 : (i == 1 ? 6'h29 : 6'h1a);
			// init to disabled with the network off, then operational
			if (i == 3 || i == 4) begin
				{c, r} = 6'h01;
				nb = (i == 4);
			end
			i_fmer_master_model.send(c, r, nb);
			chk({il, legal}, {~legal_req(c, r, nb), legal_req(c, r, nb)});
		end
		repeat (10) @(negedge clk);
		chk(i_fmer_master_model.last_rec, exp_rec(2));
		$display("state test done");
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			div_valid = 1'b1;
			divisor = 16'(rnd()) | 16'h1;
		end
		@(negedge clk);
		div_valid = 1'b0;
		divisor = 16'h0;
		@(negedge clk);
		chk(dz, 1'b0);
		div_valid = 1'b1;
		@(negedge clk);
		div_valid = 1'b0;
		chk(dz, 1'b1);
		repeat (30) @(negedge clk);
		chk(i_fmer_master_model.last_rec, exp_rec(3));
		chk({safe, hold, frq, ereg},
			{3'b101, 8'h81 | (legal_req(c, r, nb) ? 8'h00 : 8'h21)});
		i_fmer_master_model.send(3'h3, 3'h2, 1'b1);
		chk(dz, 1'b1);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk({dz, safe}, 2'b00);
		$display("division test done");
		end_sim();
	end
endmodule // fmer_top_tb
`default_nettype wire

// file: verilog/fmer_defs.vh
// constants of the supply, state-command and division fault monitor
// assumes a 25 MHz system clock and supply readings in millivolts
// Operation
// [R1] overvoltage sample counts up, else down
// [R2] fault raised when filter count reaches 50
// [R3] overvoltage clears after net 50 good samples
// [R4] overvoltage reported 0x3411, warning, 0x5, 0x2001
// [R5] undervoltage when either supply below 9 V
// [R6] undervoltage has own up/down filter counter
// [R7] undervoltage reported 0x3412, warning, 0x5, 0x2002
// [R8] undervoltage clears like overvoltage
// [R9] illegal state request flagged, code 0x5200
// [R10] fault to disabled with active error illegal
// [R11] legal state command clears illegal fault
// [R12] zero divisor flagged, code 0x6201, severe
// [R13] division fault forces fault, power cycle only
// [R14] report may wait up to 100 ms
// [R15] any fault present means safe state
// [R16] warnings only lead to fault hold, report
// [R17] severe fault leads to fault, reboot only
// [R18] sample tick periodic, 50 samples near 0.5 s
`ifndef FMER_DEFS_VH
`define FMER_DEFS_VH

// ****************************************
// timing
// ****************************************
`define FMER_CLK_HZ 25000000
`define FMER_TICK_PERIOD_US 10000
`define FMER_XVAL_DELAY_US 1000
`define FMER_XVAL_MAX_US 100000

// ****************************************
// supply thresholds and filter
// ****************************************
`define FMER_OV_LIMIT_MV 16'h8aac
`define FMER_UV_LIMIT_MV 16'h2328
`define FMER_FILTER_COUNT 6'h32

// ****************************************
// fault report records
// ****************************************
`define FMER_OV_CODE 16'h3411
`define FMER_OV_ERRREG 8'h05
`define FMER_OV_INDEX 16'h2001
`define FMER_UV_CODE 16'h3412
`define FMER_UV_ERRREG 8'h05
`define FMER_UV_INDEX 16'h2002
`define FMER_IL_CODE 16'h5200
`define FMER_IL_ERRREG 8'h21
`define FMER_IL_INDEX 16'h2003
`define FMER_DZ_CODE 16'h6201
`define FMER_DZ_ERRREG 8'h81
`define FMER_DZ_INDEX 16'h2004

// ****************************************
// device state machine codes
// ****************************************
`define FMER_ST_INIT 3'h0
`define FMER_ST_DISABLED 3'h1
`define FMER_ST_HOLD 3'h2
`define FMER_ST_ACTIVE 3'h3
`define FMER_ST_FAULT_HOLD 3'h4
`define FMER_ST_FAULT 3'h5
`define FMER_ST_FAULT_REACT 3'h6

`endif

// file: verilog/fmer_filter.v
// up/down counting filter for one supply out-of-range condition
// assumes tick_i is a one-cycle pulse on the same clock
`timescale 1ns/100ps
`default_nettype none
module fmer_filter #(
	parameter CW = 6,
	parameter [CW-1:0] LIMIT = 6'h32
) (
	// clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// sample in
	input wire tick_i,
	input wire bad_i,
	// filtered fault
	output reg fault_o
);

	reg [CW-1:0] cnt; // net count toward the next change of fault_o

	// ****************************************
	// filter counter
	// ****************************************
	// while clear, bad samples count up; while raised, good samples count up
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			cnt <= {CW{1'b0}};
			fault_o <= 1'b0;
		end else if (tick_i) begin
			// [R1] count toward or away
			if (bad_i != fault_o) begin
				// [R2] raise or clear at fifty
				if (cnt == LIMIT - 1'b1) begin
					cnt <= {CW{1'b0}};
					fault_o <= ~fault_o;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end else if (cnt != {CW{1'b0}}) begin
				// saturate at zero so stale history does not pile up
				cnt <= cnt - 1'b1;
			end
		end
	end

endmodule // fmer_filter
`default_nettype wire

// file: verilog/fmer_top.v
// fault monitor: supply filters, state-command checks, zero divisor
// and a serial fault report toward the network stack
// assumes all inputs come from logic on clk_i; no pin is sampled here
`timescale 1ns/100ps
`default_nettype none
`include "fmer_defs.vh"
module fmer_top #(
	parameter MVW = 16,
	parameter DVW = 16,
	parameter TICK_CYCLES = `FMER_CLK_HZ / 1000000 * `FMER_TICK_PERIOD_US,
	parameter XVAL_CYCLES = `FMER_CLK_HZ / 1000000 * `FMER_XVAL_DELAY_US
) (
	// clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// supply readings in millivolts
	input wire [MVW-1:0] primary_supply_mv_i,
	input wire [MVW-1:0] secondary_supply_input_mv_i,
	// device state machine requests
	input wire dsm_req_valid_i,
	input wire [2:0] dsm_cur_state_i,
	input wire [2:0] dsm_req_state_i,
	input wire nmt_operational_i,
	// division operand check
	input wire div_valid_i,
	input wire [DVW-1:0] divisor_i,
	// fault flags
	output reg ov_fault_o,
	output reg uv_fault_o,
	output reg illegal_fault_o,
	output reg divzero_fault_o,
	output reg [7:0] error_register_o,
	// reactions
	output reg safe_state_o,
	output reg fault_hold_req_o,
	output reg fault_req_o,
	output reg dsm_req_legal_o,
	// fault report
	output reg emcy_valid_o,
	output reg [15:0] emcy_code_o,
	output reg [7:0] emcy_errreg_o,
	output reg [15:0] emcy_index_o,
	output reg emcy_severe_o
);

	// ****************************************
	// declarations
	// ****************************************
	localparam TCW = 24; // tick counter width
	localparam XCW = 24; // cross-check delay width
	// full-width terms first, then cut to the counter width on purpose
	localparam integer TICK_LAST_I = TICK_CYCLES - 1;
	localparam integer XVAL_LAST_I = XVAL_CYCLES - 1;
	localparam [TCW-1:0] TICK_LAST = TICK_LAST_I[TCW-1:0];
	localparam [XCW-1:0] XVAL_LAST = XVAL_LAST_I[XCW-1:0];
	// report sequencer, one-hot
	localparam [2:0] RP_IDLE = 3'h1;
	localparam [2:0] RP_WAIT = 3'h2;
	localparam [2:0] RP_SEND = 3'h4;

	reg [TCW-1:0] tick_cnt; // sample period divider
	reg tick; // one-cycle sample strobe
	reg ov_sample; // either supply above limit
	reg uv_sample; // either supply below limit
	wire ov_filt; // filtered overvoltage
	wire uv_filt; // filtered undervoltage
	reg [3:0] flags_q; // fault flags one cycle ago
	reg [3:0] pending; // faults still to be reported
	reg [3:0] next_pending;
	reg [2:0] rp_state; // report sequencer state
	reg [XCW-1:0] xval_cnt; // cross-check wait
	reg req_legal; // combinational check of the request
	reg any_err; // any fault flag set
	wire [3:0] flags;

	assign flags = {divzero_fault_o, illegal_fault_o, uv_fault_o, ov_fault_o};

	// ****************************************
	// sample tick
	// ****************************************
	// [R18] periodic sample tick
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			tick_cnt <= {TCW{1'b0}};
			tick <= 1'b0;
		end else if (tick_cnt == TICK_LAST) begin
			tick_cnt <= {TCW{1'b0}};
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			tick <= 1'b0;
		end
	end

	// ****************************************
	// threshold compare
	// ****************************************
	// registered so the filter sees values settled a cycle before the tick
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			ov_sample <= 1'b0;
			uv_sample <= 1'b0;
		end else begin
			// [R1] either supply above
			ov_sample <= (primary_supply_mv_i > `FMER_OV_LIMIT_MV) ||
				(secondary_supply_input_mv_i > `FMER_OV_LIMIT_MV);
			// [R5] either supply below
			uv_sample <= (primary_supply_mv_i < `FMER_UV_LIMIT_MV) ||
				(secondary_supply_input_mv_i < `FMER_UV_LIMIT_MV);
		end
	end

	// ****************************************
	// supply filters
	// ****************************************
	// [R3] overvoltage raise and clear
	fmer_filter #(
		.CW(6),
		.LIMIT(`FMER_FILTER_COUNT)
	) u_ov_filter (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.tick_i(tick),
		.bad_i(ov_sample),
		.fault_o(ov_filt)
	);

	// [R6] own undervoltage counter
	// [R8] same clearing procedure
	fmer_filter #(
		.CW(6),
		.LIMIT(`FMER_FILTER_COUNT)
	) u_uv_filter (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.tick_i(tick),
		.bad_i(uv_sample),
		.fault_o(uv_filt)
	);

	// ****************************************
	// state request check
	// ****************************************
	// legal moves of the device state machine; fault state leaves only by reboot
	always @* begin
		any_err = |flags;
		req_legal = 1'b0;
		case (dsm_cur_state_i)
			`FMER_ST_INIT: begin
				// disabling from init needs network operational
				req_legal = (dsm_req_state_i == `FMER_ST_DISABLED) && nmt_operational_i;
			end
			`FMER_ST_DISABLED: begin
				req_legal = (dsm_req_state_i == `FMER_ST_HOLD) ||
					(dsm_req_state_i == `FMER_ST_INIT);
			end
			`FMER_ST_HOLD: begin
				req_legal = (dsm_req_state_i == `FMER_ST_ACTIVE) ||
					(dsm_req_state_i == `FMER_ST_DISABLED);
			end
			`FMER_ST_ACTIVE: begin
				req_legal = (dsm_req_state_i == `FMER_ST_HOLD) ||
					(dsm_req_state_i == `FMER_ST_DISABLED);
			end
			`FMER_ST_FAULT_HOLD: begin
				// hold is accepted, the state machine itself waits for no errors
				req_legal = (dsm_req_state_i == `FMER_ST_HOLD) ||
					(dsm_req_state_i == `FMER_ST_DISABLED);
			end
			`FMER_ST_FAULT: begin
				// [R10] no exit while errors stand
				req_legal = 1'b0;
			end
			default: begin
				// transient or unknown state accepts nothing
				req_legal = 1'b0;
			end
		endcase
	end

	// ****************************************
	// fault flags
	// ****************************************
	// the division fault is cleared by reset only, which stands for power cycle
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			ov_fault_o <= 1'b0;
			uv_fault_o <= 1'b0;
			illegal_fault_o <= 1'b0;
			divzero_fault_o <= 1'b0;
			dsm_req_legal_o <= 1'b0;
		end else begin
			ov_fault_o <= ov_filt;
			uv_fault_o <= uv_filt;
			dsm_req_legal_o <= dsm_req_valid_i && req_legal;
			if (dsm_req_valid_i && !req_legal) begin
				// [R9] illegal request flagged
				illegal_fault_o <= 1'b1;
			end else if (dsm_req_valid_i && req_legal) begin
				// [R11] legal command clears
				illegal_fault_o <= 1'b0;
			end
			// [R12] zero divisor
			// [R13] sticky until power cycle
			if (div_valid_i && (divisor_i == {DVW{1'b0}})) begin
				divzero_fault_o <= 1'b1;
			end
		end
	end

	// ****************************************
	// reactions
	// ****************************************
	// severe faults win over warnings, so fault hold never overlaps fault
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			safe_state_o <= 1'b0;
			fault_hold_req_o <= 1'b0;
			fault_req_o <= 1'b0;
			error_register_o <= 8'h00;
		end else begin
			// [R15] any fault means safe
			safe_state_o <= any_err;
			// [R16] warnings only
			fault_hold_req_o <= (ov_fault_o || uv_fault_o || illegal_fault_o) &&
				!divzero_fault_o;
			// [R17] severe goes to fault
			fault_req_o <= divzero_fault_o;
			error_register_o <= (ov_fault_o ? `FMER_OV_ERRREG : 8'h00) |
				(uv_fault_o ? `FMER_UV_ERRREG : 8'h00) |
				(illegal_fault_o ? `FMER_IL_ERRREG : 8'h00) |
				(divzero_fault_o ? `FMER_DZ_ERRREG : 8'h00);
		end
	end

	// ****************************************
	// report queue
	// ****************************************
	// a new fault sets its pending bit; a bit sent in the same cycle stays set
	always @* begin
		next_pending = pending | (flags & ~flags_q);
		if (rp_state == RP_SEND) begin
			if (pending[3]) begin
				next_pending[3] = (flags[3] & ~flags_q[3]);
			end else if (pending[2]) begin
				next_pending[2] = (flags[2] & ~flags_q[2]);
			end else if (pending[1]) begin
				next_pending[1] = (flags[1] & ~flags_q[1]);
			end else begin
				next_pending[0] = (flags[0] & ~flags_q[0]);
			end
		end
	end

	// edge memory and queue
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			flags_q <= 4'h0;
			pending <= 4'h0;
		end else begin
			flags_q <= flags;
			pending <= next_pending;
		end
	end

	// ****************************************
	// report sequencer
	// ****************************************
	// waits a fixed cross-check time, then sends one record, highest first
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			rp_state <= RP_IDLE;
			xval_cnt <= {XCW{1'b0}};
			emcy_valid_o <= 1'b0;
			emcy_code_o <= 16'h0000;
			emcy_errreg_o <= 8'h00;
			emcy_index_o <= 16'h0000;
			emcy_severe_o <= 1'b0;
		end else begin
			emcy_valid_o <= 1'b0;
			case (rp_state)
				RP_IDLE: begin
					// start the wait when anything is queued
					xval_cnt <= {XCW{1'b0}};
					if (|pending) begin
						rp_state <= RP_WAIT;
					end
				end
				RP_WAIT: begin
					// [R14] bounded report delay
					if (xval_cnt == XVAL_LAST) begin
						rp_state <= RP_SEND;
					end else begin
						xval_cnt <= xval_cnt + 1'b1;
					end
				end
				RP_SEND: begin
					rp_state <= RP_IDLE;
					emcy_valid_o <= 1'b1;
					emcy_severe_o <= pending[3];
					if (pending[3]) begin
						// [R12] division record
						emcy_code_o <= `FMER_DZ_CODE;
						emcy_errreg_o <= `FMER_DZ_ERRREG;
						emcy_index_o <= `FMER_DZ_INDEX;
					end else if (pending[2]) begin
						// [R9] illegal command record
						emcy_code_o <= `FMER_IL_CODE;
						emcy_errreg_o <= `FMER_IL_ERRREG;
						emcy_index_o <= `FMER_IL_INDEX;
					end else if (pending[1]) begin
						// [R7] undervoltage record
						emcy_code_o <= `FMER_UV_CODE;
						emcy_errreg_o <= `FMER_UV_ERRREG;
						emcy_index_o <= `FMER_UV_INDEX;
					end else begin
						// [R4] overvoltage record
						emcy_code_o <= `FMER_OV_CODE;
						emcy_errreg_o <= `FMER_OV_ERRREG;
						emcy_index_o <= `FMER_OV_INDEX;
					end
				end
				default: begin
					// recover from an illegal code
					rp_state <= RP_IDLE;
				end
			endcase
		end
	end

endmodule // fmer_top
`default_nettype wire
